// File: bench/sgms_loop_model.sv
// servo loop stand-in: control tick and live quantities
`timescale 1ns/100ps
module sgms_loop_model (
  input wire i_fire,
  input wire [3:0] i_src,
  input wire [31:0] i_val,
  output wire o_tick,
  output wire [15:0] o_torque,
  output wire [15:0] o_speed,
  output wire [23:0] o_accel,
  output wire [31:0] o_dev
);
  // ==========================================================
  // tick follows the request, which already moves off the edge
  assign o_tick = i_fire;
  // quantities not under test sit high to expose a wrong source pick
  assign o_torque = (i_src == 4'h0) ? i_val[15:0] : 16'h7FFF;
  assign o_speed = (i_src == 4'h1) ? i_val[15:0] : 16'h7FFF;
  assign o_accel = (i_src == 4'h2) ? i_val[23:0] : 24'h7FFFFF;
  // idle deviation stays under the overflow default
  assign o_dev = (i_src == 4'h3) ? i_val : 32'h0000_2AF8;
endmodule

// File: bench/sgms_top_sva.sv
// port assertions of the gain and mode switch block
`timescale 1ns/100ps
module sgms_top_sva (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_param_wr,
  input wire [3:0] i_param_id,
  input wire [31:0] i_param_data,
  input wire i_ctrl_tick,
  input wire [15:0] i_torque_ref,
  input wire [15:0] i_speed_ref,
  input wire [23:0] i_accel,
  input wire [31:0] i_pos_dev,
  input wire i_alarm_clear,
  input wire o_param_ack,
  input wire o_param_err,
  input wire o_mf_enable,
  input wire o_vib_supp_enable,
  input wire [14:0] o_mf_gain,
  input wire [3:0] o_switch_cond,
  input wire o_p_only,
  input wire o_dev_overflow_alarm
);
  // ==========================================================
  // quantities beyond the largest level always hit
  wire big_trq = ($signed(i_torque_ref) > 16'sh0320) || ($signed(i_torque_ref) < -16'sh0320);
  wire big_spd = ($signed(i_speed_ref) > 16'sh2710) || ($signed(i_speed_ref) < -16'sh2710);
  wire big_acc = ($signed(i_accel) > 24'sh007530) || ($signed(i_accel) < -24'sh007530);
  wire big_dev = ($signed(i_pos_dev) > 32'sh2710) || ($signed(i_pos_dev) < -32'sh2710);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // ==========================================================
  // gain write steps: in-range write, ack, then visible copy
  sequence s_gain_wr;
    i_param_wr && i_param_id == 4'h1 && i_param_data >= 32'h0000_000A
      && i_param_data <= 32'h0000_4E20;
  endsequence
  sequence s_ack_copy;
    o_param_ack && !o_param_err ##1 o_mf_gain == $past(i_param_data[14:0], 2);
  endsequence
  property p_gain_ok;
    s_gain_wr |=> s_ack_copy;
  endproperty
  property p_gain_bad;
    i_param_wr && i_param_id == 4'h1
      && (i_param_data < 32'h0000_000A || i_param_data > 32'h0000_4E20)
      |=> o_param_err && !o_param_ack;
  endproperty
  property p_vib_rsv;
    i_param_wr && i_param_id == 4'h0 && i_param_data == 32'h0000_0020 |=> o_param_err;
  endproperty
  property p_vib_mf;
    o_vib_supp_enable |-> o_mf_enable;
  endproperty
  // mode only moves on a control tick
  property p_hold;
    !i_ctrl_tick |=> $stable(o_p_only);
  endproperty
  property p_none;
    i_ctrl_tick && o_switch_cond == 4'h4 && !$past(i_param_wr) |=> !o_p_only;
  endproperty
  property p_trq;
    i_ctrl_tick && o_switch_cond == 4'h0 && !$past(i_param_wr) && big_trq |=> o_p_only;
  endproperty
  property p_spd;
    i_ctrl_tick && o_switch_cond == 4'h1 && !$past(i_param_wr) && big_spd |=> o_p_only;
  endproperty
  property p_acc;
    i_ctrl_tick && o_switch_cond == 4'h2 && !$past(i_param_wr) && big_acc |=> o_p_only;
  endproperty
  property p_dev;
    i_ctrl_tick && o_switch_cond == 4'h3 && !$past(i_param_wr) && big_dev |=> o_p_only;
  endproperty
  property p_alarm_sticky;
    o_dev_overflow_alarm && !i_alarm_clear |=> o_dev_overflow_alarm;
  endproperty
  a_gain_ok: assert property (p_gain_ok) else $error("gain write not taken");
  a_gain_bad: assert property (p_gain_bad) else $error("gain range not refused");
  a_vib_rsv: assert property (p_vib_rsv) else $error("reserved digit accepted");
  a_vib_mf: assert property (p_vib_mf) else $error("suppression without follow");
  a_hold: assert property (p_hold) else $error("mode moved without tick");
  a_none: assert property (p_none) else $error("mode set with switching off");
  a_trq: assert property (p_trq) else $error("torque hit missed");
  a_spd: assert property (p_spd) else $error("speed hit missed");
  a_acc: assert property (p_acc) else $error("accel hit missed");
  a_dev: assert property (p_dev) else $error("deviation hit missed");
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm dropped");
endmodule
bind sgms_top sgms_top_sva sva_u (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_param_wr(i_param_wr),
  .i_param_id(i_param_id), .i_param_data(i_param_data), .i_ctrl_tick(i_ctrl_tick),
  .i_torque_ref(i_torque_ref), .i_speed_ref(i_speed_ref), .i_accel(i_accel),
  .i_pos_dev(i_pos_dev), .i_alarm_clear(i_alarm_clear), .o_param_ack(o_param_ack),
  .o_param_err(o_param_err), .o_mf_enable(o_mf_enable),
  .o_vib_supp_enable(o_vib_supp_enable), .o_mf_gain(o_mf_gain),
  .o_switch_cond(o_switch_cond), .o_p_only(o_p_only),
  .o_dev_overflow_alarm(o_dev_overflow_alarm)
);

// File: bench/sgms_top_test.sv
// self-checking bench of the gain and mode switch block
`timescale 1ns/100ps
`include "sgms_regs.vh"
module sgms_top_test;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_param_wr = 1'b0;
  logic [3:0] i_param_id = 4'h0;
  logic [31:0] i_param_data = 32'h0;
  logic i_alarm_clear = 1'b0;
  logic fire = 1'b0;
  logic [3:0] src = 4'h0;
  logic [31:0] val = 32'h0;
  wire i_ctrl_tick;
  wire [15:0] i_torque_ref;
  wire [15:0] i_speed_ref;
  wire [23:0] i_accel;
  wire [31:0] i_pos_dev;
  wire o_param_ack, o_param_err, o_mf_enable, o_vib_supp_enable, o_p_only;
  wire o_dev_overflow_alarm;
  wire [14:0] o_mf_gain;
  wire [13:0] o_fwd_bias, o_rev_bias, o_ff_comp;
  wire [3:0] o_switch_cond;
  integer err_total = 0;
  integer checks = 0;
  integer cyc = 0;
  // ==========================================================
  // clock, design and loop stand-in
  always #4 i_sys_clk = ~i_sys_clk;
  sgms_top dut_u (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_param_wr(i_param_wr),
    .i_param_id(i_param_id), .i_param_data(i_param_data), .i_ctrl_tick(i_ctrl_tick),
    .i_torque_ref(i_torque_ref), .i_speed_ref(i_speed_ref), .i_accel(i_accel),
    .i_pos_dev(i_pos_dev), .i_alarm_clear(i_alarm_clear), .o_param_ack(o_param_ack),
    .o_param_err(o_param_err), .o_mf_enable(o_mf_enable),
    .o_vib_supp_enable(o_vib_supp_enable), .o_mf_gain(o_mf_gain),
    .o_fwd_bias(o_fwd_bias), .o_rev_bias(o_rev_bias), .o_ff_comp(o_ff_comp),
    .o_switch_cond(o_switch_cond), .o_p_only(o_p_only),
    .o_dev_overflow_alarm(o_dev_overflow_alarm)
  );
  sgms_loop_model loop_u (
    .i_fire(fire), .i_src(src), .i_val(val), .o_tick(i_ctrl_tick),
    .o_torque(i_torque_ref), .o_speed(i_speed_ref), .o_accel(i_accel), .o_dev(i_pos_dev)
  );
  // ==========================================================
  // compare, setting write and control tick helpers
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write pulse, answer one cycle later, copy visible on return
  task automatic wr(input logic [3:0] id, input logic [31:0] d, input logic ok);
    @(negedge i_sys_clk);
    i_param_wr = 1'b1;
    i_param_id = id;
    i_param_data = d;
    @(negedge i_sys_clk);
    i_param_wr = 1'b0;
    cmp("ack", {31'h0, ok}, {31'h0, o_param_ack});
    cmp("err", {31'h0, !ok}, {31'h0, o_param_err});
    @(negedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  // one tick with a value on the chosen quantity, then the mode
  task automatic tk(input logic [3:0] s, input logic [31:0] v, input logic exp);
    @(negedge i_sys_clk);
    fire = 1'b1;
    src = s;
    val = v;
    @(negedge i_sys_clk);
    fire = 1'b0;
    @(negedge i_sys_clk);
    cmp("p_only", {31'h0, exp}, {31'h0, o_p_only});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    cmp("mf_enable", 32'h0, {31'h0, o_mf_enable});
    cmp("vib", 32'h0, {31'h0, o_vib_supp_enable});
    cmp("gain", `SGMS_GAIN_RST, {17'h0, o_mf_gain});
    cmp("fwd", `SGMS_PCT_RST, {18'h0, o_fwd_bias});
    cmp("rev", `SGMS_PCT_RST, {18'h0, o_rev_bias});
    cmp("ff", `SGMS_PCT_RST, {18'h0, o_ff_comp});
    cmp("cond", `SGMS_SW_SEL_RST, {28'h0, o_switch_cond});
    cmp("p_only", 32'h0, {31'h0, o_p_only});
    cmp("alarm", 32'h0, {31'h0, o_dev_overflow_alarm});
  endtask
  task automatic t_settings;
    wr(4'h1, 32'h0000_0009, 1'b0);
    wr(4'h1, 32'h0000_4E21, 1'b0);
    wr(4'h1, 32'h0000_000A, 1'b1);
    cmp("gain", 32'h0000_000A, {17'h0, o_mf_gain});
    wr(4'h1, 32'h0000_4E20, 1'b1);
    cmp("gain", 32'h0000_4E20, {17'h0, o_mf_gain});
    wr(4'h2, 32'h0000_2711, 1'b0);
    wr(4'h2, 32'h0000_2710, 1'b1);
    cmp("fwd", 32'h0000_2710, {18'h0, o_fwd_bias});
    wr(4'h3, 32'h0000_0000, 1'b1);
    cmp("rev", 32'h0000_0000, {18'h0, o_rev_bias});
    wr(4'h4, 32'h0000_2711, 1'b0);
    wr(4'h4, 32'h0000_0320, 1'b1);
    cmp("ff", 32'h0000_0320, {18'h0, o_ff_comp});
    wr(4'h0, 32'h0000_0020, 1'b0);
    wr(4'h0, 32'h0000_0011, 1'b1);
    cmp("vib", 32'h1, {31'h0, o_vib_supp_enable});
    wr(4'h0, 32'h0000_0001, 1'b1);
    cmp("mf_enable", 32'h1, {31'h0, o_mf_enable});
    cmp("vib", 32'h0, {31'h0, o_vib_supp_enable});
    wr(4'h0, 32'h0000_0000, 1'b1);
    cmp("mf_enable", 32'h0, {31'h0, o_mf_enable});
    wr(4'h5, 32'h0000_0000, 1'b0);
    wr(4'h5, 32'h4000_0000, 1'b0);
    wr(4'h6, 32'h0000_0005, 1'b0);
    wr(4'h7, 32'h0000_0321, 1'b0);
    wr(4'h7, 32'h0000_0320, 1'b1);
    wr(4'h7, 32'h0000_00C8, 1'b1);
    wr(4'h8, 32'h0000_2711, 1'b0);
    wr(4'h9, 32'h0000_7531, 1'b0);
    wr(4'hA, 32'h0000_2711, 1'b0);
    wr(4'hB, 32'h0000_0000, 1'b0);
  endtask
  // level hit, one below it negated, then one beyond the largest level, negated
  task automatic t_mode;
    logic [31:0] lv [4] = '{32'h0000_00C8, 32'h0000_0064, 32'h0000_7530, 32'h0000_2710};
    logic [31:0] bg [4] = '{32'hFFFF_FCDF, 32'hFFFF_D8EF, 32'hFFFF_8ACF, 32'hFFFF_D8EF};
    for (int i = 0; i < 4; i++) begin
      wr(4'h6, i, 1'b1);
      cmp("cond", i, {28'h0, o_switch_cond});
      if (i > 0) begin
        wr(4'h7 + i[3:0], lv[i], 1'b1);
      end
      tk(i[3:0], lv[i], 1'b1);
      tk(i[3:0], 32'h1 - lv[i], 1'b0);
      tk(i[3:0], bg[i], 1'b1);
    end
    val = 32'h0;
    repeat (3) @(negedge i_sys_clk);
    cmp("p_only", 32'h1, {31'h0, o_p_only});
    wr(4'h6, 32'h0000_0004, 1'b1);
    tk(4'h4, 32'h0, 1'b0);
  endtask
  task automatic t_alarm;
    tk(4'h3, 32'h0000_6400, 1'b0);
    cmp("alarm", 32'h0, {31'h0, o_dev_overflow_alarm});
    tk(4'h3, 32'hFFFF_9BFF, 1'b0);
    cmp("alarm", 32'h1, {31'h0, o_dev_overflow_alarm});
    @(negedge i_sys_clk);
    i_alarm_clear = 1'b1;
    @(negedge i_sys_clk);
    i_alarm_clear = 1'b0;
    @(negedge i_sys_clk);
    cmp("alarm", 32'h0, {31'h0, o_dev_overflow_alarm});
    wr(4'h5, 32'h0000_0001, 1'b1);
    tk(4'h3, 32'h0000_0002, 1'b0);
    cmp("alarm", 32'h1, {31'h0, o_dev_overflow_alarm});
    // clear and a fresh detection in one cycle: detection wins
    @(negedge i_sys_clk);
    fire = 1'b1;
    i_alarm_clear = 1'b1;
    @(negedge i_sys_clk);
    fire = 1'b0;
    i_alarm_clear = 1'b0;
    @(negedge i_sys_clk);
    cmp("alarm", 32'h1, {31'h0, o_dev_overflow_alarm});
  endtask
  // ==========================================================
  // verdict, hang guard and main sequence
  task automatic wrap_up;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_resetn = 1'b1;
    t_reset;
    t_settings;
    t_mode;
    t_alarm;
    wrap_up;
  end
endmodule

// File: common/sgms_regs.vh
// setting identifiers, ranges, defaults and digit fields of the gain and mode switch block
`ifndef SGMS_REGS_VH
`define SGMS_REGS_VH

// ==========================================================
// setting identifiers on the write port
`define SGMS_ID_MF_SELECT 4'h0
`define SGMS_ID_MF_GAIN 4'h1
`define SGMS_ID_FWD_BIAS 4'h2
`define SGMS_ID_REV_BIAS 4'h3
`define SGMS_ID_FF_COMP 4'h4
`define SGMS_ID_OVF_LEVEL 4'h5
`define SGMS_ID_SW_SELECT 4'h6
`define SGMS_ID_TRQ_LEVEL 4'h7
`define SGMS_ID_SPD_LEVEL 4'h8
`define SGMS_ID_ACC_LEVEL 4'h9
`define SGMS_ID_DEV_LEVEL 4'hA

// ==========================================================
// ranges and reset values
`define SGMS_SEL_MIN 32'h0000_0000
`define SGMS_MF_SEL_MAX 32'h0000_0011
`define SGMS_MF_SEL_RST 32'h0000_0000
`define SGMS_GAIN_MIN 32'h0000_000A
`define SGMS_GAIN_MAX 32'h0000_4E20
`define SGMS_GAIN_RST 32'h0000_01F4
`define SGMS_PCT_MIN 32'h0000_0000
`define SGMS_PCT_MAX 32'h0000_2710
`define SGMS_PCT_RST 32'h0000_03E8
`define SGMS_OVF_MIN 32'h0000_0001
`define SGMS_OVF_MAX 32'h3FFF_FFFF
`define SGMS_OVF_RST 32'h0000_6400
`define SGMS_SW_SEL_MAX 32'h0000_0004
`define SGMS_SW_SEL_RST 32'h0000_0000
`define SGMS_TRQ_MAX 32'h0000_0320
`define SGMS_TRQ_RST 32'h0000_00C8
`define SGMS_LVL_MAX 32'h0000_2710
`define SGMS_ACC_MAX 32'h0000_7530
`define SGMS_LVL_RST 32'h0000_0000

// ==========================================================
// digit fields of the selection settings
`define SGMS_DIG0_LSB 0
`define SGMS_DIG1_LSB 4
`define SGMS_DIG_MAX_ONOFF 4'h1
`define SGMS_DIG_MAX_COND 4'h4
`define SGMS_COND_TORQUE 4'h0
`define SGMS_COND_SPEED 4'h1
`define SGMS_COND_ACCEL 4'h2
`define SGMS_COND_DEVIATION 4'h3
`define SGMS_COND_NONE 4'h4

`endif

// File: verilog/sgms_mag_cmp.v
// magnitude of a signed quantity compared against an unsigned level
`timescale 1ns/100ps
module sgms_mag_cmp #(
  parameter W = 16,
  parameter STRICT = 0
) (
  input wire [W-1:0] i_value,
  input wire [31:0] i_level,
  output wire o_hit
);
  // ==========================================================
  // sign-extend to 33 bits so the most negative value has a true magnitude
  wire [32:0] ext = {{(33-W){i_value[W-1]}}, i_value};
  wire [32:0] neg = ~ext + 33'h000000001;
  wire [32:0] mag33 = ext[32] ? neg : ext;
  wire [32:0] lvl33 = {1'b0, i_level};
  // strict: above the level; otherwise at or above
  assign o_hit = (STRICT != 0) ? (mag33 > lvl33) : (mag33 >= lvl33);
endmodule

// File: verilog/sgms_param_reg.v
// one range-checked setting register with a reset default
`timescale 1ns/100ps
module sgms_param_reg #(
  parameter W = 16,
  parameter [3:0] ID = 4'h0,
  parameter [31:0] MINV = 32'h0000_0000,
  parameter [31:0] MAXV = 32'h0000_FFFF,
  parameter [31:0] RSTV = 32'h0000_0000
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_wr,
  input wire [3:0] i_id,
  input wire [31:0] i_data,
  input wire i_fmt_ok,
  output reg [W-1:0] o_value_q,
  output wire o_accept
);
  // ==========================================================
  // decode and range check
  wire hit = i_wr && (i_id == ID); // this setting is addressed
  wire in_range = (i_data >= MINV) && (i_data <= MAXV); // value inside the legal span
  assign o_accept = hit && in_range && i_fmt_ok;

  // ==========================================================
  // storage; a refused value leaves the old one in place
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_value_q <= RSTV[W-1:0];
    end else if (o_accept) begin
      o_value_q <= i_data[W-1:0];
    end
  end
endmodule

// File: verilog/sgms_top.v
// tuning settings, deviation overflow alarm and P/PI mode switch decision
`timescale 1ns/100ps
`include "sgms_regs.vh"
module sgms_top (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_param_wr,
  input wire [3:0] i_param_id,
  input wire [31:0] i_param_data,
  input wire i_ctrl_tick,
  input wire [15:0] i_torque_ref,
  input wire [15:0] i_speed_ref,
  input wire [23:0] i_accel,
  input wire [31:0] i_pos_dev,
  input wire i_alarm_clear,
  output reg o_param_ack,
  output reg o_param_err,
  output reg o_mf_enable,
  output reg o_vib_supp_enable,
  output reg [14:0] o_mf_gain,
  output reg [13:0] o_fwd_bias,
  output reg [13:0] o_rev_bias,
  output reg [13:0] o_ff_comp,
  output reg [3:0] o_switch_cond,
  output reg o_p_only,
  output reg o_dev_overflow_alarm
);

  // ==========================================================
  // setting storage wires
  wire [15:0] mf_sel_q; // model following selection digits
  wire [14:0] gain_q; // model following gain, 0.1/s
  wire [13:0] fwd_q; // forward bias, 0.1 percent
  wire [13:0] rev_q; // reverse bias, 0.1 percent
  wire [13:0] ff_q; // speed feedforward, 0.1 percent
  wire [29:0] ovf_q; // overflow alarm level, reference units
  wire [15:0] sw_sel_q; // switching condition digits
  wire [9:0] trq_lvl_q; // torque level, percent
  wire [13:0] spd_lvl_q; // speed level
  wire [14:0] acc_lvl_q; // acceleration level
  wire [13:0] dev_lvl_q; // deviation level
  // per-setting accept strobes
  wire [10:0] accept;

  // ==========================================================
  // digit format checks for the two selection settings
  // model following: only digits 0/1 in the low two places, 2 is refused
  wire mf_fmt_ok = (i_param_data[31:8] == 24'h00_0000) &&
    (i_param_data[`SGMS_DIG1_LSB+3:`SGMS_DIG1_LSB] <= `SGMS_DIG_MAX_ONOFF) &&
    (i_param_data[`SGMS_DIG0_LSB+3:`SGMS_DIG0_LSB] <= `SGMS_DIG_MAX_ONOFF);
  // switching condition: one low digit from 0 to 4
  wire sw_fmt_ok = (i_param_data[31:4] == 28'h000_0000) &&
    (i_param_data[`SGMS_DIG0_LSB+3:`SGMS_DIG0_LSB] <= `SGMS_DIG_MAX_COND);

  // ==========================================================
  // setting registers, each written immediately when accepted
  // model following selection, reset to all off
  sgms_param_reg #(
    .W(16),
    .ID(`SGMS_ID_MF_SELECT),
    .MINV(`SGMS_SEL_MIN),
    .MAXV(`SGMS_MF_SEL_MAX),
    .RSTV(`SGMS_MF_SEL_RST)
  ) u_mf_sel (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(mf_fmt_ok),
    .o_value_q(mf_sel_q),
    .o_accept(accept[0])
  );
  // model following gain
  sgms_param_reg #(
    .W(15),
    .ID(`SGMS_ID_MF_GAIN),
    .MINV(`SGMS_GAIN_MIN),
    .MAXV(`SGMS_GAIN_MAX),
    .RSTV(`SGMS_GAIN_RST)
  ) u_gain (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(gain_q),
    .o_accept(accept[1])
  );
  // forward direction bias
  sgms_param_reg #(
    .W(14),
    .ID(`SGMS_ID_FWD_BIAS),
    .MINV(`SGMS_PCT_MIN),
    .MAXV(`SGMS_PCT_MAX),
    .RSTV(`SGMS_PCT_RST)
  ) u_fwd (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(fwd_q),
    .o_accept(accept[2])
  );
  // reverse direction bias
  sgms_param_reg #(
    .W(14),
    .ID(`SGMS_ID_REV_BIAS),
    .MINV(`SGMS_PCT_MIN),
    .MAXV(`SGMS_PCT_MAX),
    .RSTV(`SGMS_PCT_RST)
  ) u_rev (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(rev_q),
    .o_accept(accept[3])
  );
  // speed feedforward compensation; the 80 percent ceiling is left to the host
  sgms_param_reg #(
    .W(14),
    .ID(`SGMS_ID_FF_COMP),
    .MINV(`SGMS_PCT_MIN),
    .MAXV(`SGMS_PCT_MAX),
    .RSTV(`SGMS_PCT_RST)
  ) u_ff (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(ff_q),
    .o_accept(accept[4])
  );
  // position deviation overflow level
  sgms_param_reg #(
    .W(30),
    .ID(`SGMS_ID_OVF_LEVEL),
    .MINV(`SGMS_OVF_MIN),
    .MAXV(`SGMS_OVF_MAX),
    .RSTV(`SGMS_OVF_RST)
  ) u_ovf (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(ovf_q),
    .o_accept(accept[5])
  );
  // switching condition selection
  sgms_param_reg #(
    .W(16),
    .ID(`SGMS_ID_SW_SELECT),
    .MINV(`SGMS_SEL_MIN),
    .MAXV(`SGMS_SW_SEL_MAX),
    .RSTV(`SGMS_SW_SEL_RST)
  ) u_sw_sel (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(sw_fmt_ok),
    .o_value_q(sw_sel_q),
    .o_accept(accept[6])
  );
  // torque switching level
  sgms_param_reg #(
    .W(10),
    .ID(`SGMS_ID_TRQ_LEVEL),
    .MINV(`SGMS_SEL_MIN),
    .MAXV(`SGMS_TRQ_MAX),
    .RSTV(`SGMS_TRQ_RST)
  ) u_trq (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(trq_lvl_q),
    .o_accept(accept[7])
  );
  // speed reference switching level
  sgms_param_reg #(
    .W(14),
    .ID(`SGMS_ID_SPD_LEVEL),
    .MINV(`SGMS_SEL_MIN),
    .MAXV(`SGMS_LVL_MAX),
    .RSTV(`SGMS_LVL_RST)
  ) u_spd (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(spd_lvl_q),
    .o_accept(accept[8])
  );
  // acceleration switching level
  sgms_param_reg #(
    .W(15),
    .ID(`SGMS_ID_ACC_LEVEL),
    .MINV(`SGMS_SEL_MIN),
    .MAXV(`SGMS_ACC_MAX),
    .RSTV(`SGMS_LVL_RST)
  ) u_acc (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(acc_lvl_q),
    .o_accept(accept[9])
  );
  // position deviation switching level
  sgms_param_reg #(
    .W(14),
    .ID(`SGMS_ID_DEV_LEVEL),
    .MINV(`SGMS_SEL_MIN),
    .MAXV(`SGMS_LVL_MAX),
    .RSTV(`SGMS_LVL_RST)
  ) u_dev (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr(i_param_wr),
    .i_id(i_param_id),
    .i_data(i_param_data),
    .i_fmt_ok(1'b1),
    .o_value_q(dev_lvl_q),
    .o_accept(accept[10])
  );

  // ==========================================================
  // magnitude comparators on the live control quantities
  wire trq_hit; // torque at or above its level
  wire spd_hit; // speed at or above its level
  wire acc_hit; // acceleration at or above its level
  wire dev_hit; // deviation at or above its level
  wire ovf_hit; // deviation strictly above the alarm level
  sgms_mag_cmp #(.W(16), .STRICT(0)) u_cmp_trq (
    .i_value(i_torque_ref),
    .i_level({22'h00_0000, trq_lvl_q}),
    .o_hit(trq_hit)
  );
  sgms_mag_cmp #(.W(16), .STRICT(0)) u_cmp_spd (
    .i_value(i_speed_ref),
    .i_level({18'h0_0000, spd_lvl_q}),
    .o_hit(spd_hit)
  );
  sgms_mag_cmp #(.W(24), .STRICT(0)) u_cmp_acc (
    .i_value(i_accel),
    .i_level({17'h0_0000, acc_lvl_q}),
    .o_hit(acc_hit)
  );
  sgms_mag_cmp #(.W(32), .STRICT(0)) u_cmp_dev (
    .i_value(i_pos_dev),
    .i_level({18'h0_0000, dev_lvl_q}),
    .o_hit(dev_hit)
  );
  sgms_mag_cmp #(.W(32), .STRICT(1)) u_cmp_ovf (
    .i_value(i_pos_dev),
    .i_level({2'h0, ovf_q}),
    .o_hit(ovf_hit)
  );

  // ==========================================================
  // condition selected by the low switching digit
  reg cond_hit; // selected quantity has reached its level
  always @* begin
    case (sw_sel_q[`SGMS_DIG0_LSB+3:`SGMS_DIG0_LSB])
      `SGMS_COND_TORQUE: cond_hit = trq_hit;
      `SGMS_COND_SPEED: cond_hit = spd_hit;
      `SGMS_COND_ACCEL: cond_hit = acc_hit;
      `SGMS_COND_DEVIATION: cond_hit = dev_hit;
      default: cond_hit = 1'b0; // no mode switching, stay in PI
    endcase
  end

  // ==========================================================
  // mode decision on each control cycle tick; alarm set on a tick, cleared on request in any cycle without a tick detection
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_p_only <= 1'b0;
      o_dev_overflow_alarm <= 1'b0;
    end else begin
      // follow the condition both ways: P while it holds, PI once it lapses
      if (i_ctrl_tick) begin
        o_p_only <= cond_hit;
      end
      // sticky alarm; a detection in the clear cycle wins
      if (i_ctrl_tick && ovf_hit) begin
        o_dev_overflow_alarm <= 1'b1;
      end else if (i_alarm_clear) begin
        o_dev_overflow_alarm <= 1'b0;
      end
    end
  end

  // ==========================================================
  // write answer and registered copies of the settings
  localparam [31:0] GAIN_RST32 = `SGMS_GAIN_RST, PCT_RST32 = `SGMS_PCT_RST; // sliced at reset
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_param_ack <= 1'b0;
      o_param_err <= 1'b0;
      o_mf_enable <= 1'b0;
      o_vib_supp_enable <= 1'b0;
      o_mf_gain <= GAIN_RST32[14:0];
      o_fwd_bias <= PCT_RST32[13:0];
      o_rev_bias <= PCT_RST32[13:0];
      o_ff_comp <= PCT_RST32[13:0];
      o_switch_cond <= `SGMS_COND_TORQUE;
    end else begin
      // one pulse per write: accepted or refused
      o_param_ack <= i_param_wr && (accept != 11'h000);
      o_param_err <= i_param_wr && (accept == 11'h000);
      o_mf_enable <= mf_sel_q[`SGMS_DIG0_LSB];
      // suppression only acts together with model following
      o_vib_supp_enable <= mf_sel_q[`SGMS_DIG1_LSB] & mf_sel_q[`SGMS_DIG0_LSB];
      o_mf_gain <= gain_q;
      o_fwd_bias <= fwd_q;
      o_rev_bias <= rev_q;
      o_ff_comp <= ff_q;
      o_switch_cond <= sw_sel_q[`SGMS_DIG0_LSB+3:`SGMS_DIG0_LSB];
    end
  end
endmodule
